// File: hw/rail_sequence_track_config.sv
// register bank for adaptive loop, rail ordering and voltage tracking commands
//
// Behaviour
// [RQ1] adaptive word: enable 24, residual, gain
// [RQ2] adaptive word resets to 015a0190h
// [RQ3] prequel: on after enable and peer good
// [RQ4] sequel: off after peer down, with delays
// [RQ5] prequel peer id in bits 12:8
// [RQ6] sequel peer id in bits 4:0
// [RQ7] bits 15 and 7 enable prequel/sequel
// [RQ8] ordering word resets with both off
// [RQ9] tracking only for standalone two-phase device
// [RQ10] tracking bit 7 enables tracking
// [RQ11] bit 2 selects half tracking ratio
// [RQ12] limit bit picks target or reference cap
// [RQ13] tracking word resets to zero
// [RQ14] unused bits read zero, ignore writes
// [RQ15] tracking limit select is bit 1
`timescale 1ns/10ps
module rail_sequence_track_config (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic [7:0] cmdCode,
  input wire logic [31:0] cmdWriteData,
  input wire logic enablePin,
  input wire logic operationOn,
  input wire logic currentShareGroup,
  input wire logic offDelayDone,
  input wire rail_seq_pkg::peer_event_type peerEvent,
  output logic [31:0] cmdReadData,
  output logic cmdReadValid,
  output logic cmdUnmapped,
  output logic outputEnable,
  output rail_seq_pkg::loop_cfg_type loopCfg
);
  logic [31:0] adaptive_q, adaptive_d;
  logic [15:0] railOrder_q, railOrder_d;
  logic [7:0] voltFollow_q, voltFollow_d;
  logic [31:0] readData_d;
  logic readValid_d, unmapped_d;
  rail_seq_pkg::loop_cfg_type loopCfg_d;
  logic gateOn;
  logic [2:0] enSync_q;
  logic enStable_q, enStable_d;

  // register writes, masked so unused positions stay zero
  always_comb begin
    adaptive_d = adaptive_q;
    railOrder_d = railOrder_q;
    voltFollow_d = voltFollow_q;
    if (cmdWrite) begin
      unique case (cmdCode)
        rail_seq_pkg::CMD_ADAPTIVE_LOOP: adaptive_d = cmdWriteData & rail_seq_pkg::ADAPTIVE_MASK; // [RQ1] [RQ14]
        rail_seq_pkg::CMD_RAIL_ORDER: railOrder_d = cmdWriteData[15:0] & rail_seq_pkg::RAIL_ORDER_MASK; // [RQ5] [RQ6] [RQ14]
        rail_seq_pkg::CMD_VOLT_FOLLOW: voltFollow_d = cmdWriteData[7:0] & rail_seq_pkg::VOLT_FOLLOW_MASK; // [RQ14]
        default: ;
      endcase
    end
  end

  // read mux, narrower words zero-extended
  always_comb begin
    readData_d = 32'h0;
    readValid_d = cmdRead;
    unmapped_d = 1'b0;
    if (cmdRead) begin
      unique case (cmdCode)
        rail_seq_pkg::CMD_ADAPTIVE_LOOP: readData_d = adaptive_q;
        rail_seq_pkg::CMD_RAIL_ORDER: readData_d = {16'h0, railOrder_q};
        rail_seq_pkg::CMD_VOLT_FOLLOW: readData_d = {24'h0, voltFollow_q};
        default: unmapped_d = 1'b1;
      endcase
    end
    if (cmdWrite && !(cmdCode inside {rail_seq_pkg::CMD_ADAPTIVE_LOOP, rail_seq_pkg::CMD_RAIL_ORDER,
        rail_seq_pkg::CMD_VOLT_FOLLOW})) begin
      unmapped_d = 1'b1;
    end
  end

  // decoded loop and tracking settings; tracking forced off in a sharing group
  always_comb begin
    loopCfg_d.loopEnable = adaptive_q[rail_seq_pkg::ADAPTIVE_EN_BIT]; // [RQ1]
    loopCfg_d.residual = adaptive_q[rail_seq_pkg::RESIDUAL_LSB +: 8];
    loopCfg_d.gain = adaptive_q[15:0];
    loopCfg_d.followEnable = voltFollow_q[rail_seq_pkg::FOLLOW_EN_BIT] && !currentShareGroup; // [RQ9] [RQ10]
    loopCfg_d.followHalf = voltFollow_q[rail_seq_pkg::FOLLOW_HALF_BIT]; // [RQ11]
    loopCfg_d.followLimitRef = voltFollow_q[rail_seq_pkg::FOLLOW_LIMIT_BIT]; // [RQ12] [RQ15]
  end

  // pin enable: three stages, accepted once the last two agree
  always_comb begin
    enStable_d = enStable_q;
    if (enSync_q[1] == enSync_q[2]) begin
      enStable_d = enSync_q[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adaptive_q <= rail_seq_pkg::ADAPTIVE_RESET; // [RQ2]
      railOrder_q <= rail_seq_pkg::RAIL_ORDER_RESET; // [RQ8]
      voltFollow_q <= rail_seq_pkg::VOLT_FOLLOW_RESET; // [RQ13]
      cmdReadData <= 32'h0;
      cmdReadValid <= 1'b0;
      cmdUnmapped <= 1'b0;
      loopCfg <= '0;
      enSync_q <= 3'h0;
      enStable_q <= 1'b0;
      outputEnable <= 1'b0;
    end else begin
      adaptive_q <= adaptive_d;
      railOrder_q <= railOrder_d;
      voltFollow_q <= voltFollow_d;
      cmdReadData <= readData_d;
      cmdReadValid <= readValid_d;
      cmdUnmapped <= unmapped_d;
      loopCfg <= loopCfg_d;
      enSync_q <= {enSync_q[1:0], enablePin};
      enStable_q <= enStable_d;
      outputEnable <= gateOn;
    end
  end

  // enable request is pin or operation state
  rail_order_gate u_gate (
    .clk(clk),
    .rst(rst),
    .orderCfg(railOrder_q),
    .enableRequest(enStable_q || operationOn),
    .offDelayDone(offDelayDone),
    .peerEvent(peerEvent),
    .outputOn(gateOn)
  );

  a_unused_zero: assert property (@(posedge clk) disable iff (rst) // [RQ14]
    (adaptive_q & ~rail_seq_pkg::ADAPTIVE_MASK) == 32'h0 && (railOrder_q & ~rail_seq_pkg::RAIL_ORDER_MASK) == 16'h0)
    else $error("unused bits set");
  a_write_takes: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    cmdWrite && cmdCode == rail_seq_pkg::CMD_ADAPTIVE_LOOP |=>
    adaptive_q == ($past(cmdWriteData) & rail_seq_pkg::ADAPTIVE_MASK))
    else $error("adaptive write lost");
  a_order_write: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    cmdWrite && cmdCode == rail_seq_pkg::CMD_RAIL_ORDER |=> railOrder_q[12:8] == $past(cmdWriteData[12:8]))
    else $error("prequel id not stored");
  a_read_order: assert property (@(posedge clk) disable iff (rst) // [RQ6]
    cmdRead && !cmdWrite && cmdCode == rail_seq_pkg::CMD_RAIL_ORDER |=> cmdReadData == {16'h0, $past(railOrder_q)})
    else $error("ordering read wrong");
  a_follow_group: assert property (@(posedge clk) disable iff (rst) // [RQ9]
    currentShareGroup |=> !loopCfg.followEnable)
    else $error("tracking in sharing group");
  a_follow_ratio: assert property (@(posedge clk) disable iff (rst) // [RQ11]
    loopCfg.followHalf == $past(voltFollow_q[2]))
    else $error("ratio select wrong");
  a_follow_limit: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    loopCfg.followLimitRef == $past(voltFollow_q[1]))
    else $error("limit select wrong");
  a_follow_enable: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    loopCfg.followEnable |-> $past(voltFollow_q[7]))
    else $error("tracking on without bit 7");
  a_seq_no_mode: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    !railOrder_q[15] && (enStable_q || operationOn) && !gateOn |=> gateOn)
    else $error("no prequel yet output held");
endmodule

// File: hw/rail_seq_pkg.sv
// shared constants and carriers for the rail ordering and tracking register bank
package rail_seq_pkg;
  // command codes
  localparam logic [7:0] CMD_ADAPTIVE_LOOP = 8'hdf;
  localparam logic [7:0] CMD_RAIL_ORDER = 8'he0;
  localparam logic [7:0] CMD_VOLT_FOLLOW = 8'he1;
  // reset values
  localparam logic [31:0] ADAPTIVE_RESET = 32'h015a0190;
  localparam logic [15:0] RAIL_ORDER_RESET = 16'h0000;
  localparam logic [7:0] VOLT_FOLLOW_RESET = 8'h00;
  // writable bit masks, unused positions clear
  localparam logic [31:0] ADAPTIVE_MASK = 32'h01ffffff;
  localparam logic [15:0] RAIL_ORDER_MASK = 16'h9f9f;
  localparam logic [7:0] VOLT_FOLLOW_MASK = 8'h86;
  // field positions
  localparam int ADAPTIVE_EN_BIT = 24;
  localparam int RESIDUAL_LSB = 16;
  localparam int PREQUEL_EN_BIT = 15;
  localparam int PREQUEL_ID_LSB = 8;
  localparam int SEQUEL_EN_BIT = 7;
  localparam int SEQUEL_ID_LSB = 0;
  localparam int FOLLOW_EN_BIT = 7;
  localparam int FOLLOW_HALF_BIT = 2;
  localparam int FOLLOW_LIMIT_BIT = 1;
  localparam int PEER_ID_W = 5;

  // one event seen on the peer bus
  typedef struct packed {
    logic valid;
    logic powerGood;
    logic powerDown;
    logic [4:0] railId;
  } peer_event_type;

  // configuration decoded for the output logic
  typedef struct packed {
    logic loopEnable;
    logic [7:0] residual;
    logic [15:0] gain;
    logic followEnable;
    logic followHalf;
    logic followLimitRef;
  } loop_cfg_type;
endpackage

// File: hw/rail_order_gate.sv
// output enable gating from prequel and sequel peer events
`timescale 1ns/10ps
module rail_order_gate (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] orderCfg,
  input wire logic enableRequest,
  input wire logic offDelayDone,
  input wire rail_seq_pkg::peer_event_type peerEvent,
  output logic outputOn
);
  logic prequelSeen_q, prequelSeen_d;
  logic sequelSeen_q, sequelSeen_d;
  logic outputOn_d;
  logic preEn, seqEn, preHit, seqHit;

  // decode the ordering word
  assign preEn = orderCfg[rail_seq_pkg::PREQUEL_EN_BIT];
  assign seqEn = orderCfg[rail_seq_pkg::SEQUEL_EN_BIT];
  assign preHit = peerEvent.valid && peerEvent.powerGood &&
    peerEvent.railId == orderCfg[rail_seq_pkg::PREQUEL_ID_LSB +: rail_seq_pkg::PEER_ID_W];
  assign seqHit = peerEvent.valid && peerEvent.powerDown &&
    peerEvent.railId == orderCfg[rail_seq_pkg::SEQUEL_ID_LSB +: rail_seq_pkg::PEER_ID_W];

  // latched peer events; a new event beats a clear in the same cycle
  always_comb begin
    prequelSeen_d = prequelSeen_q;
    sequelSeen_d = sequelSeen_q;
    // a finished power-good must not switch the rail straight back on after an off
    if (!enableRequest || (outputOn && !outputOn_d)) begin
      prequelSeen_d = 1'b0;
    end
    if (preHit) begin
      prequelSeen_d = 1'b1; // [RQ3]
    end
    if (!outputOn_d) begin
      sequelSeen_d = 1'b0;
    end
    if (seqHit && seqEn) begin
      sequelSeen_d = 1'b1; // [RQ4]
    end
  end

  // on needs enable, plus prequel good when prequel is enabled; off waits for turn-off delay
  always_comb begin
    outputOn_d = outputOn;
    if (!outputOn) begin
      outputOn_d = enableRequest && (!preEn || prequelSeen_q || preHit); // [RQ3] [RQ7]
    end else if (!enableRequest && offDelayDone) begin
      outputOn_d = 1'b0;
    end else if (seqEn && sequelSeen_q && offDelayDone) begin
      outputOn_d = 1'b0; // [RQ4]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prequelSeen_q <= 1'b0;
      sequelSeen_q <= 1'b0;
      outputOn <= 1'b0;
    end else begin
      prequelSeen_q <= prequelSeen_d;
      sequelSeen_q <= sequelSeen_d;
      outputOn <= outputOn_d;
    end
  end

  // output never rises while prequel mode waits for its peer
  a_prequel_hold: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    $rose(outputOn) && $past(preEn) |-> $past(prequelSeen_q) || $past(preHit))
    else $error("output rose before prequel power-good");
  // sequel off only after delay done
  a_sequel_delay: assert property (@(posedge clk) disable iff (rst) // [RQ4]
    $fell(outputOn) |-> $past(offDelayDone))
    else $error("output dropped without turn-off delay");
endmodule

// File: dv/peer_rail_model.sv
// behavioural peer rail that announces power good and power down events
`timescale 1ns/10ps
module peer_rail_model (
  input wire logic clk,
  input wire logic sendGood,
  input wire logic sendDown,
  input wire logic [4:0] myId,
  output rail_seq_pkg::peer_event_type peerEvent
);
  // event lasts one cycle, launched just after the edge that saw the request
  always_ff @(posedge clk) begin
    peerEvent <= '0;
    if (sendGood || sendDown) begin
      peerEvent <= {1'b1, sendGood, sendDown, myId};
    end
  end
endmodule

// File: dv/rail_sequence_track_config_tb_top.sv
// self-checking bench for the rail ordering and tracking register bank
`timescale 1ns/10ps
module rail_sequence_track_config_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmdWrite = 1'b0, cmdRead = 1'b0, enablePin = 1'b0, operationOn = 1'b0;
  logic currentShareGroup = 1'b0, offDelayDone = 1'b0, sendGood = 1'b0, sendDown = 1'b0;
  logic [7:0] cmdCode = 8'h00;
  logic [31:0] cmdWriteData = 32'h00000000;
  logic [4:0] peerId = 5'h00;
  rail_seq_pkg::peer_event_type peerEvent;
  rail_seq_pkg::loop_cfg_type loopCfg;
  logic [31:0] cmdReadData;
  logic cmdReadValid, cmdUnmapped, outputEnable;
  int errors = 0;
  int num_checks = 0;

  always #10 clk = ~clk;

  rail_sequence_track_config DUT (.clk(clk), .rst(rst), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdCode(cmdCode), .cmdWriteData(cmdWriteData), .enablePin(enablePin), .operationOn(operationOn),
    .currentShareGroup(currentShareGroup), .offDelayDone(offDelayDone), .peerEvent(peerEvent),
    .cmdReadData(cmdReadData), .cmdReadValid(cmdReadValid), .cmdUnmapped(cmdUnmapped),
    .outputEnable(outputEnable), .loopCfg(loopCfg));

  peer_rail_model peer (.clk(clk), .sendGood(sendGood), .sendDown(sendDown), .myId(peerId),
    .peerEvent(peerEvent));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // all bus tasks start and end on a falling edge
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    cmdCode = code;
    cmdWriteData = data;
    cmdWrite = 1'b1;
    @(negedge clk);
    cmdWrite = 1'b0;
  endtask

  // answer is registered, so it is settled at the next falling edge
  task automatic rd(input logic [7:0] code, input logic [31:0] exp);
    cmdCode = code;
    cmdRead = 1'b1;
    @(negedge clk);
    cmdRead = 1'b0;
    check("read valid", 32'h1, {31'h0, cmdReadValid});
    check("read data", exp, cmdReadData);
  endtask

  task automatic peer_send(input logic [4:0] id, input logic good);
    peerId = id;
    sendGood = good;
    sendDown = !good;
    @(negedge clk);
    sendGood = 1'b0;
    sendDown = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // bounded wait; the pin synchroniser adds a few cycles
  task automatic wait_out(input logic exp);
    int i;
    for (i = 0; i < 20 && outputEnable !== exp; i++) begin
      @(negedge clk);
    end
    check("output enable", {31'h0, exp}, {31'h0, outputEnable});
    if (outputEnable !== exp) begin
      stop_test();
    end
  endtask

  task automatic test_reset();
    rd(rail_seq_pkg::CMD_ADAPTIVE_LOOP, rail_seq_pkg::ADAPTIVE_RESET);
    rd(rail_seq_pkg::CMD_RAIL_ORDER, 32'h00000000);
    rd(rail_seq_pkg::CMD_VOLT_FOLLOW, 32'h00000000);
    check("gain", 32'd400, {16'h0, loopCfg.gain});
    check("residual", 32'd90, {24'h0, loopCfg.residual});
    check("loop enable", 32'h1, {31'h0, loopCfg.loopEnable});
    $display("test reset done");
  endtask

  task automatic test_fields();
    wr(rail_seq_pkg::CMD_ADAPTIVE_LOOP, 32'hffffffff);
    rd(rail_seq_pkg::CMD_ADAPTIVE_LOOP, 32'h01ffffff);
    wr(rail_seq_pkg::CMD_ADAPTIVE_LOOP, 32'hfeab1234);
    rd(rail_seq_pkg::CMD_ADAPTIVE_LOOP, 32'h00ab1234);
    check("cfg word", 32'h00ab1234, {7'h0, loopCfg.loopEnable, loopCfg.residual, loopCfg.gain});
    wr(rail_seq_pkg::CMD_RAIL_ORDER, 32'hffffffff);
    rd(rail_seq_pkg::CMD_RAIL_ORDER, 32'h00009f9f);
    wr(rail_seq_pkg::CMD_VOLT_FOLLOW, 32'hffffffff);
    rd(rail_seq_pkg::CMD_VOLT_FOLLOW, 32'h00000086);
    check("follow bits", 32'h7, {29'h0, loopCfg.followEnable, loopCfg.followHalf, loopCfg.followLimitRef});
    currentShareGroup = 1'b1;
    repeat (2) @(negedge clk);
    check("follow in group", 32'h0, {31'h0, loopCfg.followEnable});
    currentShareGroup = 1'b0;
    wr(rail_seq_pkg::CMD_VOLT_FOLLOW, 32'h00000004);
    @(negedge clk);
    check("follow half only", 32'h2, {29'h0, loopCfg.followEnable, loopCfg.followHalf, loopCfg.followLimitRef});
    cmdCode = 8'he2;
    cmdRead = 1'b1;
    @(negedge clk);
    cmdRead = 1'b0;
    check("unmapped flag", 32'h1, {31'h0, cmdUnmapped});
    check("unmapped valid", 32'h1, {31'h0, cmdReadValid});
    $display("test fields done");
  endtask

  task automatic test_order();
    wr(rail_seq_pkg::CMD_RAIL_ORDER, 32'h00008300);
    enablePin = 1'b1;
    repeat (8) @(negedge clk);
    check("held for prequel", 32'h0, {31'h0, outputEnable});
    peer_send(5'h05, 1'b1);
    check("wrong peer good", 32'h0, {31'h0, outputEnable});
    peer_send(5'h03, 1'b1);
    wait_out(1'b1);
    wr(rail_seq_pkg::CMD_RAIL_ORDER, 32'h00008386);
    peer_send(5'h07, 1'b0);
    peer_send(5'h06, 1'b0);
    check("off delay pending", 32'h1, {31'h0, outputEnable});
    offDelayDone = 1'b1;
    wait_out(1'b0);
    repeat (6) @(negedge clk);
    check("stays off after sequel", 32'h0, {31'h0, outputEnable});
    $display("test order done");
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    test_reset();
    test_fields();
    test_order();
    stop_test();
  end
endmodule
